// ### design/adcsc_ctrl.sv
// ADC sequence controller: control registers, sequencing, results
`timescale 1ns/1ns
`default_nettype none
`include "adcsc_map.svh"
module adcsc_ctrl
  import adcsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ctl2_wr,
  input wire adcsc_ctl2_t ctl2_wdata,
  input wire logic ctl3_wr,
  input wire adcsc_ctl3_t ctl3_wdata,
  input wire logic ctl4_wr,
  input wire logic ctl5_wr,
  input wire adcsc_ctl5_t ctl5_wdata,
  input wire logic test_rst_wr,
  input wire logic flag_clr,
  input wire logic cmp_hi,
  output logic [3:0] mux_chan,
  output logic mux_internal,
  output logic [`ADCSC_SAR_BITS-1:0] test_rdata,
  output logic sequence_complete_flag,
  output logic busy,
  output logic result_valid,
  output logic [2:0] result_slot,
  output logic [15:0] result_data,
  output adcsc_ctl2_t ctl2,
  output adcsc_ctl3_t ctl3,
  output adcsc_ctl5_t ctl5
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] seq_len(input adcsc_ctl5_t c5, input adcsc_ctl3_t c3);
    if (c3.single_conv_sel)
      seq_len = `ADCSC_LEN_ONE;
    else if (c5.eight_conv_seq_sel)
      seq_len = `ADCSC_LEN_EIGHT;
    else
      seq_len = `ADCSC_LEN_FOUR;
  endfunction

  function automatic logic [15:0] format_result(input logic [`ADCSC_SAR_BITS-1:0] v, input adcsc_ctl2_t c2);
    logic [`ADCSC_SAR_BITS-1:0] s;
    s = c2.signed_result_sel ? {~v[`ADCSC_SAR_BITS-1], v[`ADCSC_SAR_BITS-2:0]} : v;
    if (c2.result_justify_sel)
      format_result = {{(16-`ADCSC_SAR_BITS){c2.signed_result_sel & s[`ADCSC_SAR_BITS-1]}}, s};
    else
      format_result = {s, {(16-`ADCSC_SAR_BITS){1'b0}}};
  endfunction

  // ****************************************
  // Control registers and sequencer
  // ****************************************
  adcsc_ctl2_t ctl2_q, ctl2_d;
  adcsc_ctl3_t ctl3_q, ctl3_d;
  adcsc_ctl5_t ctl5_q, ctl5_d;
  adcsc_state_t st_q, st_d;
  logic [2:0] chan_q, chan_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] slot_q, slot_d;
  logic scf_q, scf_d;
  logic rv_q, rv_d;
  logic [15:0] res_q, res_d;
  logic [2:0] rslot_q, rslot_d;
  logic sar_start, sar_abort, sar_busy, sar_done;
  logic [`ADCSC_SAR_BITS-1:0] sar_val;
  logic restart;

  // Writes to control 2/3 deliberately absent: they never abort
  assign restart = ctl4_wr | ctl5_wr;

  always_comb begin
    ctl2_d = ctl2_wr ? ctl2_wdata : ctl2_q;
    ctl3_d = ctl3_wr ? ctl3_wdata : ctl3_q;
    ctl5_d = ctl5_wr ? ctl5_wdata : ctl5_q;
    st_d = st_q;
    chan_d = chan_q;
    cnt_d = cnt_q;
    slot_d = slot_q;
    scf_d = scf_q;
    rv_d = 1'b0;
    res_d = res_q;
    rslot_d = rslot_q;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    if (flag_clr)
      scf_d = 1'b0;
    if (test_rst_wr) begin
      st_d = ADCSC_IDLE;
      scf_d = 1'b0;
      sar_abort = 1'b1;
      cnt_d = '0;
      slot_d = '0;
    end else if (restart) begin
      sar_abort = 1'b1;
      if (ctl5_wr)
        scf_d = 1'b0;
      // Start channel taken from all three bits, never masked
      chan_d = {ctl5_d.chan_sel_bit2, ctl5_d.chan_sel_bit1, ctl5_d.chan_sel_bit0};
      cnt_d = '0;
      if (!ctl3_d.fifo_mode || ctl5_wr)
        slot_d = '0;
      st_d = ADCSC_CONV;
      sar_start = 1'b1;
    end else begin
      case (st_q)
        ADCSC_IDLE: begin
        end
        ADCSC_CONV: begin
          if (sar_done) begin
            rv_d = 1'b1;
            res_d = format_result(sar_val, ctl2_q);
            rslot_d = slot_q;
            slot_d = 3'(slot_q + 3'd1);
            cnt_d = 4'(cnt_q + 4'd1);
            if (4'(cnt_q + 4'd1) >= seq_len(ctl5_q, ctl3_q)) begin
              st_d = ADCSC_DONE;
            end else begin
              chan_d = 3'(chan_q + 3'd1);
              sar_start = 1'b1;
            end
          end
        end
        ADCSC_DONE: begin
          scf_d = 1'b1;
          if (ctl5_q.scan_mode) begin
            chan_d = {ctl5_q.chan_sel_bit2, ctl5_q.chan_sel_bit1, ctl5_q.chan_sel_bit0};
            cnt_d = '0;
            if (!ctl3_q.fifo_mode)
              slot_d = '0;
            st_d = ADCSC_CONV;
            sar_start = 1'b1;
          end else begin
            st_d = ADCSC_IDLE;
          end
        end
        default: st_d = ADCSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctl2_q <= `ADCSC_CTL2_RST;
      ctl3_q <= `ADCSC_CTL3_RST;
      ctl5_q <= `ADCSC_CTL5_RST;
      st_q <= ADCSC_IDLE;
      chan_q <= '0;
      cnt_q <= '0;
      slot_q <= '0;
      scf_q <= 1'b0;
      rv_q <= 1'b0;
      res_q <= '0;
      rslot_q <= '0;
    end else begin
      ctl2_q <= ctl2_d;
      ctl3_q <= ctl3_d;
      ctl5_q <= ctl5_d;
      st_q <= st_d;
      chan_q <= chan_d;
      cnt_q <= cnt_d;
      slot_q <= slot_d;
      scf_q <= scf_d;
      rv_q <= rv_d;
      res_q <= res_d;
      rslot_q <= rslot_d;
    end
  end

  adcsc_sar u_sar (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(sar_start),
    .abort(sar_abort & ~sar_start),
    .cmp_hi(cmp_hi),
    .sar(sar_val),
    .busy(sar_busy),
    .done(sar_done)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign mux_chan = {1'b0, chan_q};
  assign mux_internal = ctl5_q.special_channel_sel;
  assign test_rdata = sar_val;
  assign sequence_complete_flag = scf_q;
  assign busy = (st_q != ADCSC_IDLE) | sar_busy;
  assign result_valid = rv_q;
  assign result_slot = rslot_q;
  assign result_data = res_q;
  assign ctl2 = ctl2_q;
  assign ctl3 = ctl3_q;
  assign ctl5 = ctl5_q;
endmodule // adcsc_ctrl
`default_nettype wire

// ### design/adcsc_map.svh
// Constants for the ADC sequence controller
`ifndef ADCSC_MAP_SVH
`define ADCSC_MAP_SVH
`define ADCSC_SAR_BITS 10
`define ADCSC_CONV_CYCLES 5'd12
`define ADCSC_LEN_FOUR 4'd4
`define ADCSC_LEN_EIGHT 4'd8
`define ADCSC_LEN_ONE 4'd1
`define ADCSC_CTL2_RST 2'h0
`define ADCSC_CTL3_RST 2'h0
`define ADCSC_CTL5_RST 6'h00
`endif

// ### design/adcsc_pkg.sv
// Types for the ADC sequence controller
`include "adcsc_map.svh"
package adcsc_pkg;
  typedef struct packed {
    logic result_justify_sel;
    logic signed_result_sel;
  } adcsc_ctl2_t;
  typedef struct packed {
    logic fifo_mode;
    logic single_conv_sel;
  } adcsc_ctl3_t;
  typedef struct packed {
    logic scan_mode;
    logic eight_conv_seq_sel;
    logic special_channel_sel;
    logic chan_sel_bit2;
    logic chan_sel_bit1;
    logic chan_sel_bit0;
  } adcsc_ctl5_t;
  typedef enum logic [1:0] {
    ADCSC_IDLE,
    ADCSC_CONV,
    ADCSC_DONE
  } adcsc_state_t;
endpackage

// ### design/adcsc_sar.sv
// Successive approximation step engine for one conversion
`timescale 1ns/1ns
`default_nettype none
`include "adcsc_map.svh"
module adcsc_sar
  import adcsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  input wire logic abort,
  input wire logic cmp_hi,
  output logic [`ADCSC_SAR_BITS-1:0] sar,
  output logic busy,
  output logic done
);
  logic [`ADCSC_SAR_BITS-1:0] sar_q, sar_d, bit_q, bit_d;
  logic busy_q, busy_d, done_q, done_d;

  always_comb begin
    sar_d = sar_q;
    bit_d = bit_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort) begin
      busy_d = 1'b0;
    end else if (start) begin
      bit_d = {1'b1, {(`ADCSC_SAR_BITS-1){1'b0}}};
      sar_d = bit_d;
      busy_d = 1'b1;
    end else if (busy_q) begin
      // Keep trial bit if input is above trial level
      sar_d = cmp_hi ? sar_q : (sar_q & ~bit_q);
      bit_d = bit_q >> 1;
      sar_d = sar_d | bit_d;
      if (bit_q[0]) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sar_q <= '0;
      bit_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      sar_q <= sar_d;
      bit_q <= bit_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign sar = sar_q;
  assign busy = busy_q;
  assign done = done_q;
endmodule // adcsc_sar
`default_nettype wire

// ### verif/adcsc_checker.sv
// Port assertions for the ADC sequence controller
`timescale 1ns/1ns
`default_nettype none
module adcsc_checker
  import adcsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ctl2_wr,
  input wire logic ctl3_wr,
  input wire logic ctl4_wr,
  input wire logic ctl5_wr,
  input wire adcsc_ctl5_t ctl5_wdata,
  input wire logic test_rst_wr,
  input wire logic [3:0] mux_chan,
  input wire logic mux_internal,
  input wire logic sequence_complete_flag,
  input wire logic busy,
  input wire logic result_valid,
  input wire adcsc_ctl3_t ctl3
);
  // ****************
  // Sequencing checks
  // ****************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Test reset outranks the restart of a control 4/5 write; register writes still land
  wire logic go = ctl5_wr && !test_rst_wr;
  wire logic calm = !ctl4_wr && !ctl5_wr && !test_rst_wr;
  // Cycles since a control 5 write with no restart since; parks at zero
  logic [4:0] since_go_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      since_go_q <= 5'h00;
    else if (go)
      since_go_q <= 5'h01;
    else if (calm && since_go_q != 5'h00 && since_go_q != 5'h1f)
      since_go_q <= 5'(since_go_q + 5'h01);
    else
      since_go_q <= 5'h00;
  end
  start_chan_a: assert property (go |=> busy && mux_chan[2:0] == $past(ctl5_wdata[2:0]))
    else $error("start channel wrong");
  ref_sel_a: assert property (go |=> mux_internal == $past(ctl5_wdata.special_channel_sel))
    else $error("reference select wrong");
  abort_run_a: assert property (ctl4_wr && !test_rst_wr |=> busy)
    else $error("control 4 write left idle");
  keep_run_a: assert property (busy && !result_valid && (ctl2_wr || ctl3_wr) && calm |=> busy)
    else $error("config write aborted");
  flag_clear_a: assert property (go |=> !sequence_complete_flag)
    else $error("flag not cleared");
  first_result_a: assert property (since_go_q == 5'h0c |-> result_valid)
    else $error("first result late");
  test_reset_a: assert property (test_rst_wr |=> !busy && !result_valid)
    else $error("test reset ignored");
  single_flag_a: assert property (result_valid && ctl3.single_conv_sel && calm |-> ##[1:3] sequence_complete_flag)
    else $error("flag missing");
endmodule // adcsc_checker
bind adcsc_ctrl adcsc_checker u_chk (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .ctl2_wr(ctl2_wr),
  .ctl3_wr(ctl3_wr),
  .ctl4_wr(ctl4_wr),
  .ctl5_wr(ctl5_wr),
  .ctl5_wdata(ctl5_wdata),
  .test_rst_wr(test_rst_wr),
  .mux_chan(mux_chan),
  .mux_internal(mux_internal),
  .sequence_complete_flag(sequence_complete_flag),
  .busy(busy),
  .result_valid(result_valid),
  .ctl3(ctl3)
);
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the ADC sequence controller
`timescale 1ns/1ns
`default_nettype none
`include "adcsc_map.svh"
module tb_top
  import adcsc_pkg::*;
;
  typedef struct packed {
    logic c;
    adcsc_ctl2_t r2;
    adcsc_ctl3_t r3;
    adcsc_ctl5_t r5;
    logic [15:0] d;
    logic [3:0] n;
  } adcsc_row_t;
  logic clk_sys, rstn, ctl2_wr, ctl3_wr, ctl4_wr, ctl5_wr, test_rst_wr, flag_clr, cmp_hi;
  adcsc_ctl2_t ctl2_wdata, ctl2;
  adcsc_ctl3_t ctl3_wdata, ctl3;
  adcsc_ctl5_t ctl5_wdata, ctl5;
  logic [3:0] mux_chan;
  logic [2:0] result_slot;
  logic [15:0] result_data;
  logic [`ADCSC_SAR_BITS-1:0] test_rdata;
  logic mux_internal, sequence_complete_flag, busy, result_valid;
  int compares = 0, miscompares = 0, cyc = 0;
  // First result slot expected by seq
  logic [2:0] sbase = 3'h0;
  // Right/left justify, signed by msb flip, all comparator levels high or low
  adcsc_row_t rows [5] = '{
    {1'b1, 2'h2, 2'h0, 6'h05, 16'h03ff, 4'h4},
    {1'b1, 2'h0, 2'h0, 6'h17, 16'hffc0, 4'h8},
    {1'b1, 2'h3, 2'h1, 6'h02, 16'h01ff, 4'h1},
    {1'b1, 2'h1, 2'h2, 6'h08, 16'h7fc0, 4'h4},
    {1'b0, 2'h2, 2'h0, 6'h03, 16'h0000, 4'h4}};
  adcsc_ctrl uut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ctl2_wr(ctl2_wr),
    .ctl2_wdata(ctl2_wdata),
    .ctl3_wr(ctl3_wr),
    .ctl3_wdata(ctl3_wdata),
    .ctl4_wr(ctl4_wr),
    .ctl5_wr(ctl5_wr),
    .ctl5_wdata(ctl5_wdata),
    .test_rst_wr(test_rst_wr),
    .flag_clr(flag_clr),
    .cmp_hi(cmp_hi),
    .mux_chan(mux_chan),
    .mux_internal(mux_internal),
    .test_rdata(test_rdata),
    .sequence_complete_flag(sequence_complete_flag),
    .busy(busy),
    .result_valid(result_valid),
    .result_slot(result_slot),
    .result_data(result_data),
    .ctl2(ctl2),
    .ctl3(ctl3),
    .ctl5(ctl5)
  );
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up;
    end
  end
  // ************
  // Shared tasks
  // ************
  task step;
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Strobes {test, clr, c5, c4, c3, c2}; trailing step keeps pulses apart
  task wr(input logic [5:0] s);
    {test_rst_wr, flag_clr, ctl5_wr, ctl4_wr, ctl3_wr, ctl2_wr} = s;
    step;
    {test_rst_wr, flag_clr, ctl5_wr, ctl4_wr, ctl3_wr, ctl2_wr} = 6'h00;
    step;
  endtask
  task automatic seq(input logic [15:0] d, input logic [3:0] n);
    logic [3:0] k;
    int c;
    k = 4'h0;
    c = 0;
    while (sequence_complete_flag !== 1'b1 && c < 400) begin
      step;
      c++;
      if (result_valid === 1'b1) begin
        chk({13'h0000, result_slot}, {13'h0000, 3'(sbase + k[2:0])});
        k++;
        chk(result_data, d);
      end
    end
    chk({12'h000, k}, {12'h000, n});
  endtask
  task wrap_up;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ************
  // Main sequence
  // ************
  initial begin
    {rstn, test_rst_wr, flag_clr, ctl5_wr, ctl4_wr, ctl3_wr, ctl2_wr, cmp_hi} = 8'h00;
    ctl2_wdata = 2'h2;
    ctl3_wdata = 2'h0;
    ctl5_wdata = 6'h00;
    repeat (5) step;
    rstn = 1'b1;
    step;
    chk({4'h0, ctl2, ctl3, ctl5, sequence_complete_flag, busy}, 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      cmp_hi = rows[i].c;
      ctl2_wdata = rows[i].r2;
      ctl3_wdata = rows[i].r3;
      ctl5_wdata = rows[i].r5;
      wr(6'h03);
      wr(6'h08);
      chk({12'h000, mux_internal, mux_chan[2:0]}, {12'h000, rows[i].r5[3:0]});
      chk({12'h000, ctl2, ctl3}, {12'h000, rows[i].r2, rows[i].r3});
      seq(rows[i].d, rows[i].n);
      chk({6'h00, test_rdata}, {6'h00, {10{rows[i].c}}});
      $display("row %0d done", i);
    end
    // Scan of single conversions must flag and restart each round
    cmp_hi = 1'b1;
    ctl2_wdata = 2'h2;
    ctl3_wdata = 2'h1;
    ctl5_wdata = 6'h22;
    wr(6'h03);
    wr(6'h08);
    seq(16'h03ff, 4'h1);
    wr(6'h10);
    seq(16'h03ff, 4'h1);
    ctl3_wdata = 2'h0;
    ctl5_wdata = 6'h10;
    wr(6'h02);
    wr(6'h08);
    $display("scan test done");
    repeat (3) step;
    wr(6'h04);
    repeat (6) begin
      step;
      chk({15'h0000, result_valid}, 16'h0000);
    end
    seq(16'h03ff, 4'h8);
    $display("restart test done");
    ctl5_wdata = 6'h00;
    wr(6'h08);
    repeat (3) step;
    wr(6'h03);
    seq(16'h03ff, 4'h4);
    $display("config write test done");
    // Fifo mode keeps the slot count across a control 4 restart
    ctl3_wdata = 2'h2;
    wr(6'h02);
    wr(6'h10);
    wr(6'h04);
    sbase = 3'h4;
    seq(16'h03ff, 4'h4);
    sbase = 3'h0;
    $display("fifo test done");
    wr(6'h08);
    repeat (3) step;
    wr(6'h20);
    chk({14'h0000, busy, sequence_complete_flag}, 16'h0000);
    repeat (30) step;
    chk({14'h0000, busy, sequence_complete_flag}, 16'h0000);
    $display("test reset done");
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
